// [pps_defs.svh]
// timing and encoding constants for the psu protection status logic
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
`define PPS_CLK_HZ 100000000
`define PPS_MAIN_RETRY_MS 1000
`define PPS_SBY_RETRY_MS 2000
`define PPS_BLINK_MS 500
`define PPS_MAX_ATTEMPTS 3'h5
`define PPS_CNT_W 28
`endif

// [pps_pkg.sv]
// types shared by the psu protection status logic
`default_nettype none
package pps_pkg;
    // input voltage range classes from the input monitor
    typedef enum logic [1:0] {
        PPS_VIN_OK,
        PPS_VIN_WARN,
        PPS_VIN_BAD
    } pps_vin_t;
    // output indicator modes
    typedef enum logic [2:0] {
        PPS_LED_OFF,
        PPS_LED_GREEN,
        PPS_LED_GREEN_BLINK,
        PPS_LED_AMBER_BLINK,
        PPS_LED_AMBER
    } pps_led_t;
    // analog comparator results, all active high
    typedef struct packed {
        logic main_oc;
        logic sby_oc;
        logic temp_shut;
        logic temp_recover;
        logic temp_warn;
        logic warn_other;
        logic fault_other;
    } pps_sense_t;
    // per-led drive pair
    typedef struct packed {
        logic green;
        logic amber;
    } pps_drive_t;
endpackage : pps_pkg
`default_nettype wire

// [pps_top.sv]
// fault supervision and status indicator logic of the power module
`include "pps_defs.svh"
`default_nettype none
// How it works
// - shut down at 75C, recover 4C lower
// - warn at 65C without shutting down
// - main overcurrent shuts main output down
// - main restarts after 1 s, retrips
// - latch clears on enable toggle or repower
// - standby overcurrent shuts standby output down
// - standby retries every 2 s forever
// - input led solid green when normal
// - input led blinks green in warn range
// - input led off when out of range
// - output led green when both outputs on
// - output led blinks green standby only
// - output led blinks amber on warning
// - output led solid amber on fault
// - alert and led warning or fault together
// - main enabled only while enable held low
module pps_top
    import pps_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic CLK_EN_IN,
    input wire logic MAIN_OUTPUT_ENABLE_N_IN,
    input wire pps_sense_t SENSE_IN,
    input wire pps_vin_t VIN_CLASS_IN,
    output logic MAIN_ON_OUT,
    output logic SBY_ON_OUT,
    output logic MAIN_LATCHED_OUT,
    output logic ALERT_OUT_N,
    output pps_drive_t IN_LED_OUT,
    output pps_drive_t OUT_LED_OUT
);
    // cycle counts derived from the millisecond figures
    localparam int unsigned CYC_PER_MS = `PPS_CLK_HZ / 1000;
    localparam logic [`PPS_CNT_W-1:0] MAIN_WAIT =
        `PPS_CNT_W'(`PPS_MAIN_RETRY_MS * CYC_PER_MS - 1);
    localparam logic [`PPS_CNT_W-1:0] SBY_WAIT =
        `PPS_CNT_W'(`PPS_SBY_RETRY_MS * CYC_PER_MS - 1);
    localparam logic [`PPS_CNT_W-1:0] BLINK_HALF =
        `PPS_CNT_W'(`PPS_BLINK_MS * CYC_PER_MS - 1);

    // two-stage synchronisers for the sense, range and enable inputs, one per bit
    localparam int SW = $bits(pps_sense_t) + $bits(pps_vin_t) + 1;
    logic [SW-1:0] raw_in;
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    assign raw_in = {SENSE_IN, VIN_CLASS_IN, MAIN_OUTPUT_ENABLE_N_IN};
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            // first stage feeds only the second stage
            always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    sync1_reg[gi] <= (gi == 0);
                    sync2_reg[gi] <= (gi == 0);
                end else if (CLK_EN_IN) begin
                    sync1_reg[gi] <= raw_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    // named views of synchronised inputs
    pps_sense_t sense;
    pps_vin_t vin;
    wire enable_n = sync2_reg[0];
    assign vin = pps_vin_t'(sync2_reg[2:1]);
    assign sense = pps_sense_t'(sync2_reg[SW-1:3]);

    // enable edge detect, previous sample
    logic enable_n_reg;
    // rising edge of the enable pin means host released the output
    wire enable_toggle = enable_n & ~enable_n_reg;

    // over-temperature shutdown with hysteresis
    logic ot_reg;
    logic ot_next;
    // shut at trip point, stay off until the lower recovery point
    assign ot_next = sense.temp_shut ? 1'b1 :
                     (sense.temp_recover ? 1'b0 : ot_reg);

    // main output supervisor states
    typedef enum logic [1:0] {
        M_RUN,
        M_WAIT,
        M_LATCH
    } pps_main_st_t;
    pps_main_st_t main_st_reg;
    pps_main_st_t main_st_next;
    logic [`PPS_CNT_W-1:0] main_cnt_reg;
    logic [`PPS_CNT_W-1:0] main_cnt_next;
    logic [2:0] tries_reg;
    logic [2:0] tries_next;
    // the main output is only allowed while the host holds enable low
    wire main_allowed = ~enable_n & ~ot_reg;

    always_comb begin
        main_st_next = main_st_reg;
        main_cnt_next = main_cnt_reg;
        tries_next = tries_reg;
        unique case (main_st_reg)
            M_RUN: begin
                if (sense.main_oc && main_allowed) begin
                    main_st_next = M_WAIT;
                    main_cnt_next = '0;
                    if (tries_reg == `PPS_MAX_ATTEMPTS) begin
                        main_st_next = M_LATCH;
                    end
                end else if (!main_allowed) begin
                    // clean restart after disable forgets old attempts
                    tries_next = '0;
                end
            end
            M_WAIT: begin
                if (main_cnt_reg == MAIN_WAIT) begin
                    main_st_next = M_RUN;
                    tries_next = tries_reg + 3'h1;
                end else begin
                    main_cnt_next = main_cnt_reg + 1'b1;
                end
            end
            M_LATCH: begin
                // only a host enable toggle clears it; repower is reset
                if (enable_toggle) begin
                    main_st_next = M_RUN;
                    tries_next = '0;
                end
            end
            default: main_st_next = M_RUN;
        endcase
    end

    // standby retry timer, never latches
    logic sby_off_reg;
    logic sby_off_next;
    logic [`PPS_CNT_W-1:0] sby_cnt_reg;
    logic [`PPS_CNT_W-1:0] sby_cnt_next;
    assign sby_off_next = sby_off_reg ? (sby_cnt_reg != SBY_WAIT)
                                      : sense.sby_oc;
    assign sby_cnt_next = sby_off_reg ? sby_cnt_reg + 1'b1 : '0;

    // blink divider, equal on and off halves
    logic [`PPS_CNT_W-1:0] blink_cnt_reg;
    logic blink_reg;
    wire blink_wrap = blink_cnt_reg == BLINK_HALF;

    // status roll-up
    wire main_on = (main_st_reg == M_RUN) && main_allowed;
    wire sby_on = ~sby_off_reg && ~ot_reg;
    wire fault = ot_reg | sby_off_reg | (main_st_reg != M_RUN)
                 | sense.fault_other;
    wire warn = sense.temp_warn | sense.warn_other;

    // output indicator selection by priority
    pps_led_t out_mode;
    assign out_mode = fault ? PPS_LED_AMBER :
                      warn ? PPS_LED_AMBER_BLINK :
                      (main_on && sby_on) ? PPS_LED_GREEN :
                      sby_on ? PPS_LED_GREEN_BLINK :
                      PPS_LED_OFF;
    pps_drive_t out_led_next;
    pps_drive_t in_led_next;
    assign out_led_next.green = (out_mode == PPS_LED_GREEN) |
        ((out_mode == PPS_LED_GREEN_BLINK) & blink_reg);
    assign out_led_next.amber = (out_mode == PPS_LED_AMBER) |
        ((out_mode == PPS_LED_AMBER_BLINK) & blink_reg);
    // input indicator from the input range class
    assign in_led_next.green = (vin == PPS_VIN_OK) |
        ((vin == PPS_VIN_WARN) & blink_reg);
    assign in_led_next.amber = 1'b0;

    // state registers
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            enable_n_reg <= 1'b1;
            ot_reg <= 1'b0;
            main_st_reg <= M_RUN;
            main_cnt_reg <= '0;
            tries_reg <= '0;
            sby_off_reg <= 1'b0;
            sby_cnt_reg <= '0;
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
        end else if (CLK_EN_IN) begin
            enable_n_reg <= enable_n;
            ot_reg <= ot_next;
            main_st_reg <= main_st_next;
            main_cnt_reg <= main_cnt_next;
            tries_reg <= tries_next;
            sby_off_reg <= sby_off_next;
            sby_cnt_reg <= sby_cnt_next;
            blink_cnt_reg <= blink_wrap ? '0 : blink_cnt_reg + 1'b1;
            blink_reg <= blink_wrap ? ~blink_reg : blink_reg;
        end
    end

    // registered outputs
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            MAIN_ON_OUT <= 1'b0;
            SBY_ON_OUT <= 1'b0;
            MAIN_LATCHED_OUT <= 1'b0;
            ALERT_OUT_N <= 1'b1;
            IN_LED_OUT <= '0;
            OUT_LED_OUT <= '0;
        end else if (CLK_EN_IN) begin
            MAIN_ON_OUT <= main_on;
            SBY_ON_OUT <= sby_on;
            MAIN_LATCHED_OUT <= main_st_reg == M_LATCH;
            // same cycle as the amber indicator modes
            ALERT_OUT_N <= ~(fault | warn);
            IN_LED_OUT <= in_led_next;
            OUT_LED_OUT <= out_led_next;
        end
    end
endmodule : pps_top
`default_nettype wire

// [pps_top_properties.sv]
// assertion checker for the protection status logic
`default_nettype none
module pps_top_properties
    import pps_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic CLK_EN_IN,
    input wire logic MAIN_OUTPUT_ENABLE_N_IN,
    input wire pps_sense_t SENSE_IN,
    input wire pps_vin_t VIN_CLASS_IN,
    input wire logic MAIN_ON_OUT,
    input wire logic SBY_ON_OUT,
    input wire logic MAIN_LATCHED_OUT,
    input wire logic ALERT_OUT_N,
    input wire pps_drive_t IN_LED_OUT,
    input wire pps_drive_t OUT_LED_OUT
);
    default clocking @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    // six edges cover both sync stages and the state update
    sequence s_moc;
        (CLK_EN_IN && SENSE_IN.main_oc) [*6];
    endsequence
    sequence s_hot;
        (CLK_EN_IN && SENSE_IN.temp_shut) [*6];
    endsequence
    // a timed restart may show main on for one cycle before the retrip
    chk_main_oc_off: assert property (s_moc |->
        !MAIN_ON_OUT || !$past(MAIN_ON_OUT))
        else $error("main on under overcurrent");
    chk_hot_both_off: assert property (s_hot |->
        !MAIN_ON_OUT && !SBY_ON_OUT) else $error("outputs on when hot");
    chk_fault_amber: assert property (s_hot |->
        !ALERT_OUT_N && OUT_LED_OUT == 2'b01) else $error("no amber");
    // a standby retry may show it on for one cycle before the retrip
    chk_sby_oc_off: assert property (
        (CLK_EN_IN && SENSE_IN.sby_oc) [*6] |->
        !SBY_ON_OUT || !$past(SBY_ON_OUT))
        else $error("standby on under overcurrent");
    chk_enable_high_off: assert property (
        (CLK_EN_IN && MAIN_OUTPUT_ENABLE_N_IN) [*6] |-> !MAIN_ON_OUT)
        else $error("main on while disabled");
    chk_alert_no_green: assert property (
        !ALERT_OUT_N |-> !OUT_LED_OUT.green) else $error("alert green");
    chk_quiet_no_amber: assert property (
        ALERT_OUT_N |-> !OUT_LED_OUT.amber) else $error("amber no alert");
    chk_in_led_ok: assert property (
        (VIN_CLASS_IN == PPS_VIN_OK) [*6] |-> IN_LED_OUT == 2'b10)
        else $error("input led not green");
    chk_in_led_bad: assert property (
        VIN_CLASS_IN[1] [*6] |-> IN_LED_OUT == 2'b00)
        else $error("input led lit");
endmodule : pps_top_properties
bind pps_top pps_top_properties u_chk (
    .REF_CLK_IN(REF_CLK_IN),
    .ARST_N_IN(ARST_N_IN),
    .CLK_EN_IN(CLK_EN_IN),
    .MAIN_OUTPUT_ENABLE_N_IN(MAIN_OUTPUT_ENABLE_N_IN),
    .SENSE_IN(SENSE_IN),
    .VIN_CLASS_IN(VIN_CLASS_IN),
    .MAIN_ON_OUT(MAIN_ON_OUT),
    .SBY_ON_OUT(SBY_ON_OUT),
    .MAIN_LATCHED_OUT(MAIN_LATCHED_OUT),
    .ALERT_OUT_N(ALERT_OUT_N),
    .IN_LED_OUT(IN_LED_OUT),
    .OUT_LED_OUT(OUT_LED_OUT)
);
`default_nettype wire

// [pps_host.sv]
// host model driving the main output enable pin
`default_nettype none
module pps_host (
    input wire logic clk_in,
    input wire logic want_main_in,
    output logic enable_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // an idle host leaves the pin released, which reads high;
    // one process owns the pin so it has a single driver
    initial begin
        enable_n_out = 1'b1;
        // low requests main power; a low-high cycle clears a latch
        forever begin
            @(posedge clk_in);
            enable_n_out <= #1 !want_main_in;
        end
    end
endmodule : pps_host
`default_nettype wire

// [tb.sv]
// self-checking testbench for the protection status logic
`default_nettype none
module tb;
    import pps_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0; // active low
    logic want = 1'b1; // host asks for main power
    logic clk_en = 1'b1; // block clock enable, all state frozen when low
    logic en_n;
    logic [6:0] sense = 7'h00;
    pps_vin_t vin = PPS_VIN_OK;
    logic m_on, s_on, latch, alert_n;
    pps_drive_t in_led, out_led;
    logic [7:0] e, k; // expected value and compare mask
    logic [1:0] r;
    int bad_count = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    pps_host host (.clk_in(clk), .want_main_in(want), .enable_n_out(en_n));
    pps_top uut (.REF_CLK_IN(clk), .ARST_N_IN(rst_n), .CLK_EN_IN(clk_en),
        .MAIN_OUTPUT_ENABLE_N_IN(en_n), .SENSE_IN(sense),
        .VIN_CLASS_IN(vin), .MAIN_ON_OUT(m_on), .SBY_ON_OUT(s_on),
        .MAIN_LATCHED_OUT(latch), .ALERT_OUT_N(alert_n),
        .IN_LED_OUT(in_led), .OUT_LED_OUT(out_led));
    // waits whole cycles, then steps past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // masked compare of all outputs; blink bits are masked off
    task automatic chk(input string w, input logic [7:0] x,
        input logic [7:0] m);
        logic [7:0] s;
        s = {m_on, s_on, latch, alert_n, out_led, in_led};
        num_checks++;
        if ((s & m) !== (x & m)) begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, x & m, s & m);
        end
    endtask : chk
    // six cycles exceed the four-cycle answer time
    task automatic go(input logic [6:0] s);
        sense = s;
        cyc(6);
    endtask : go
    // two cycles of reset, outputs checked while it is held
    task automatic rst(input string done);
        $display("test done: %s", done);
        rst_n = 1'b0;
        sense = 7'h00;
        cyc(2);
        chk("reset", 8'h10, 8'hFF);
        rst_n = 1'b1;
        cyc(6);
    endtask : rst
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        void'($urandom(32'h9894));
        rst("start");
        go(7'h03); // fault and warning at once
        chk("priority", 8'h06, 8'h3F);
        rst("priority");
        go(7'h14); // hot, so also past warning
        chk("hot", 8'h06, 8'hFF);
        go(7'h04); // cooled but not past hysteresis
        chk("hysteresis", 8'h00, 8'hC0);
        go(7'h08);
        chk("recovered", 8'hDA, 8'hFF);
        go(7'h04);
        chk("warn", 8'hC2, 8'hFB);
        rst("temperature");
        clk_en = 1'b0; // frozen: the trip must not be seen yet
        go(7'h40);
        chk("frozen", 8'hDA, 8'hFF);
        clk_en = 1'b1;
        cyc(6);
        chk("main trip", 8'h46, 8'hFF);
        go(7'h00); // still inside the one second wait
        chk("main wait", 8'h46, 8'hFF);
        rst("main overcurrent");
        go(7'h20);
        chk("sby trip", 8'h86, 8'hFF);
        go(7'h00);
        chk("sby wait", 8'h06, 8'h7F);
        rst("standby overcurrent");
        want = 1'b0;
        cyc(8);
        chk("standby only", 8'h52, 8'hF7);
        want = 1'b1;
        cyc(8);
        chk("enabled", 8'hDA, 8'hFF);
        rst("enable");
        repeat (24) begin
            r = 2'($urandom % 4); // bit0 fault, bit1 warning
            vin = pps_vin_t'($urandom % 4);
            go({5'h00, r});
            e = {3'h6, !r, r[0] ? 2'b01 : {!r[1], 1'b0}, vin == 0, 1'b0};
            k = {r[0] ? 2'b00 : 2'b11, 3'h7, r != 2, vin != 1, 1'b1};
            chk("random", e, k);
        end
        rst("random");
        complete_run();
    end
endmodule : tb
`default_nettype wire
